// >>> design/spc_regs.svh
// Constants for the system PLL configuration and lock status block
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
`define SPC_FBDIV_W 10
`define SPC_FBDIV_MIN 10'h06C
`define SPC_FBDIV_MAX 10'h22C
`define SPC_FBDIV_RST 10'h06C
`define SPC_DOUBLER_RST 1'b0
`define SPC_FREQ_M_W 48
`define SPC_FREQ_N_W 16
`define SPC_LOCK_MARGIN_BASE 4'h4
`endif

// >>> design/spc_pkg.sv
// Types for the system PLL configuration and lock status block
package spc_pkg;
   typedef enum logic [0:0] {
      SPC_ST_LOAD = 1'b0,
      SPC_ST_RUN = 1'b1
   } spc_state_t;
   typedef enum logic [1:0] {
      SPC_SRC_NONE = 2'b00,
      SPC_SRC_OTP = 2'b01,
      SPC_SRC_EEPROM = 2'b10
   } spc_src_t;
endpackage

// >>> design/spc_sys_pll_cfg.sv
// System PLL configuration, frequency word and loss-of-lock status
// What this block does
// (RULE1) Frequencies are a 48-bit numerator over a 16-bit denominator, in hertz.
// (RULE2) A setting picks direct crystal reference or reference through the doubler.
// (RULE3) Feedback divider accepts any integer from 108 to 556.
// (RULE4) Configuring party should aim for a PLL frequency of 13.4 to 13.9 GHz.
// (RULE5) At reset, load fields from OTP or EEPROM, whichever is enabled and valid.
// (RULE6) After the reset sequence, host may rewrite the fields at any time.
// (RULE7) Lock limits derive from the active configuration, no user thresholds.
// (RULE8) Loss-of-lock alarm is readable as status and optionally routed to GPIO.
// (RULE9) PLL output is the high-speed source for every fractional output divider.
// (RULE10) Loss-of-lock status is a level, updated synchronously as the comparison changes.
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.svh"
module spc_sys_pll_cfg #(
   parameter int VC_W = 8
) (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CLK_EN_I,
   input wire logic OTP_EN_I,
   input wire logic OTP_VALID_I,
   input wire logic OTP_DOUBLER_I,
   input wire logic [9:0] OTP_FBDIV_I,
   input wire logic EE_EN_I,
   input wire logic EE_VALID_I,
   input wire logic EE_DOUBLER_I,
   input wire logic [9:0] EE_FBDIV_I,
   input wire logic HOST_WR_I,
   input wire logic HOST_DOUBLER_I,
   input wire logic [9:0] HOST_FBDIV_I,
   input wire logic [47:0] XTAL_M_I,
   input wire logic [15:0] XTAL_N_I,
   input wire logic [VC_W-1:0] LOOP_VCTRL_I,
   input wire logic LOL_GPIO_EN_I,
   output logic RESET_DONE_O,
   output spc_pkg::spc_src_t LOAD_SRC_O,
   output logic HOST_REJ_O,
   output logic DOUBLER_EN_O,
   output logic [9:0] FBDIV_O,
   output logic [47:0] FREQ_M_O,
   output logic [15:0] FREQ_N_O,
   output logic LOL_STATUS_O,
   output logic GPIO_LOL_O,
   output logic FRAC_DIV_SRC_EN_O
);
   import spc_pkg::*;

   // The lock window reaches at most 20 codes either side of mid-scale
   if (VC_W < 6 || VC_W > 16) begin : gen_vc_w_check
      $error("VC_W must lie between 6 and 16");
   end

   // Divider range test shared by load and host paths
   function automatic logic fb_ok(input logic [9:0] v);
      fb_ok = (v >= `SPC_FBDIV_MIN) && (v <= `SPC_FBDIV_MAX);
   endfunction

   spc_state_t state_q, state_d;
   spc_src_t src_q, src_d;
   logic dbl_q, dbl_d;
   logic [9:0] fb_q, fb_d;
   logic otp_ok, ee_ok, host_ok;

   assign otp_ok = OTP_EN_I && OTP_VALID_I && fb_ok(OTP_FBDIV_I);
   assign ee_ok = EE_EN_I && EE_VALID_I && fb_ok(EE_FBDIV_I);
   assign host_ok = HOST_WR_I && (state_q == SPC_ST_RUN) && fb_ok(HOST_FBDIV_I);

   // Configuration loading and host rewrites
   always_comb begin
      state_d = state_q;
      src_d = src_q;
      dbl_d = dbl_q;
      fb_d = fb_q;
      case (state_q)
         SPC_ST_LOAD: begin
            state_d = SPC_ST_RUN;
            if (otp_ok) begin // [RULE5]
               src_d = SPC_SRC_OTP;
               dbl_d = OTP_DOUBLER_I;
               fb_d = OTP_FBDIV_I;
            end else if (ee_ok) begin // [RULE5]
               src_d = SPC_SRC_EEPROM;
               dbl_d = EE_DOUBLER_I;
               fb_d = EE_FBDIV_I;
            end
         end
         SPC_ST_RUN: begin
            if (host_ok) begin // [RULE6] [RULE2] [RULE3]
               dbl_d = HOST_DOUBLER_I;
               fb_d = HOST_FBDIV_I;
            end
         end
         default: state_d = SPC_ST_LOAD;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_q <= SPC_ST_LOAD;
         src_q <= SPC_SRC_NONE;
         dbl_q <= `SPC_DOUBLER_RST;
         fb_q <= `SPC_FBDIV_RST;
      end else if (CLK_EN_I) begin
         state_q <= state_d;
         src_q <= src_d;
         dbl_q <= dbl_d;
         fb_q <= fb_d;
      end
   end

   // Lock window from the active configuration
   logic [VC_W-1:0] vc_mid, margin, lo_lim, hi_lim;
   logic [58:0] prod;
   logic [10:0] mult_fb;
   logic lol_q, lol_d, fdsrc_q, fdsrc_d;
   logic [47:0] fm_q, fm_d;
   logic [15:0] fn_q, fn_d;

   assign vc_mid = VC_W'(1) << (VC_W - 1);
   assign margin = VC_W'(`SPC_LOCK_MARGIN_BASE) + VC_W'(fb_q[9:6]) + VC_W'(dbl_q); // [RULE7]
   assign lo_lim = vc_mid - margin;
   assign hi_lim = vc_mid + margin;
   assign mult_fb = dbl_q ? {fb_q, 1'b0} : {1'b0, fb_q}; // [RULE2]
   assign prod = 59'(XTAL_M_I) * 59'(mult_fb);

   always_comb begin
      lol_d = (state_q != SPC_ST_RUN) || (LOOP_VCTRL_I < lo_lim) || (LOOP_VCTRL_I > hi_lim); // [RULE10] [RULE7]
      fdsrc_d = !lol_d; // [RULE9]
      fm_d = prod[47:0]; // [RULE1]
      fn_d = XTAL_N_I; // [RULE1]
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         lol_q <= 1'b1;
         fdsrc_q <= 1'b0;
         fm_q <= 48'h0;
         fn_q <= 16'h1;
      end else if (CLK_EN_I) begin
         lol_q <= lol_d;
         fdsrc_q <= fdsrc_d;
         fm_q <= fm_d;
         fn_q <= fn_d;
      end
   end

   // Output wiring
   assign RESET_DONE_O = (state_q == SPC_ST_RUN);
   assign LOAD_SRC_O = src_q;
   assign HOST_REJ_O = CLK_EN_I && HOST_WR_I && !host_ok;
   assign DOUBLER_EN_O = dbl_q;
   assign FBDIV_O = fb_q;
   assign FREQ_M_O = fm_q;
   assign FREQ_N_O = fn_q;
   assign LOL_STATUS_O = lol_q;
   assign GPIO_LOL_O = lol_q && LOL_GPIO_EN_I; // [RULE8]
   assign FRAC_DIV_SRC_EN_O = fdsrc_q;

   // Assertions sample on the system clock and rest during reset
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   // Load and host write checks
   chk_fbdiv_in_range: assert property (fb_q >= `SPC_FBDIV_MIN && fb_q <= `SPC_FBDIV_MAX) // [RULE3]
      else $error("feedback divider out of range");
   chk_host_rewrite: assert property (CLK_EN_I && host_ok |=> fb_q == $past(HOST_FBDIV_I)) // [RULE6]
      else $error("host divider write not applied");
   chk_host_doubler: assert property (CLK_EN_I && host_ok |=> dbl_q == $past(HOST_DOUBLER_I)) // [RULE2]
      else $error("host doubler write not applied");
   chk_host_refused: assert property (CLK_EN_I && HOST_WR_I && state_q == SPC_ST_RUN // [RULE3]
      && !fb_ok(HOST_FBDIV_I) |=> $stable(fb_q) && $stable(dbl_q))
      else $error("refused host write changed the configuration");
   chk_load_from_otp: assert property (CLK_EN_I && state_q == SPC_ST_LOAD && otp_ok // [RULE5]
      |=> fb_q == $past(OTP_FBDIV_I) && src_q == SPC_SRC_OTP && state_q == SPC_ST_RUN)
      else $error("otp load wrong");
   chk_load_doubler: assert property (CLK_EN_I && state_q == SPC_ST_LOAD && otp_ok // [RULE2]
      |=> dbl_q == $past(OTP_DOUBLER_I))
      else $error("otp doubler not loaded");
   chk_load_from_ee: assert property (CLK_EN_I && state_q == SPC_ST_LOAD && !otp_ok && ee_ok // [RULE5]
      |=> fb_q == $past(EE_FBDIV_I) && src_q == SPC_SRC_EEPROM)
      else $error("eeprom load wrong");
   chk_load_default: assert property (CLK_EN_I && state_q == SPC_ST_LOAD && !otp_ok && !ee_ok // [RULE5]
      |=> src_q == SPC_SRC_NONE && $stable(fb_q) && $stable(dbl_q))
      else $error("defaults not kept without a valid source");
   chk_done_after_load: assert property (CLK_EN_I && state_q == SPC_ST_LOAD |=> RESET_DONE_O) // [RULE6]
      else $error("reset sequence did not complete");

   // Lock window and alarm checks
   chk_lock_centre: assert property (CLK_EN_I && state_q == SPC_ST_RUN && LOOP_VCTRL_I == vc_mid // [RULE10]
      |=> !LOL_STATUS_O)
      else $error("centred control voltage flagged unlocked");
   chk_lock_floor: assert property (CLK_EN_I && LOOP_VCTRL_I == '0 |=> LOL_STATUS_O) // [RULE7]
      else $error("rail control voltage not flagged");
   chk_lock_ceiling: assert property (CLK_EN_I && LOOP_VCTRL_I == '1 |=> LOL_STATUS_O) // [RULE7]
      else $error("top rail control voltage not flagged");
   chk_lock_inside: assert property (CLK_EN_I && state_q == SPC_ST_RUN // [RULE7]
      && LOOP_VCTRL_I >= vc_mid - VC_W'(`SPC_LOCK_MARGIN_BASE)
      && LOOP_VCTRL_I <= vc_mid + VC_W'(`SPC_LOCK_MARGIN_BASE) |=> !LOL_STATUS_O)
      else $error("control voltage inside the narrowest window flagged unlocked");
   chk_lock_outside: assert property (CLK_EN_I // [RULE7]
      && (LOOP_VCTRL_I < vc_mid - VC_W'(`SPC_LOCK_MARGIN_BASE + 16)
      || LOOP_VCTRL_I > vc_mid + VC_W'(`SPC_LOCK_MARGIN_BASE + 16)) |=> LOL_STATUS_O)
      else $error("control voltage beyond the widest window flagged locked");
   chk_gpio_route: assert property (!LOL_GPIO_EN_I |-> !GPIO_LOL_O) // [RULE8]
      else $error("alarm on gpio while routing off");
   chk_gpio_follow: assert property (LOL_GPIO_EN_I |-> GPIO_LOL_O == LOL_STATUS_O) // [RULE8]
      else $error("gpio does not follow the alarm");
   chk_fdiv_source: assert property (FRAC_DIV_SRC_EN_O |-> !LOL_STATUS_O) // [RULE9]
      else $error("divider source enabled while unlocked");
   chk_fdiv_before_load: assert property (CLK_EN_I && state_q == SPC_ST_LOAD |=> !FRAC_DIV_SRC_EN_O) // [RULE9]
      else $error("divider source enabled before load");

   // Frequency word and clock enable checks
   chk_freq_denom: assert property (CLK_EN_I |=> FREQ_N_O == $past(XTAL_N_I)) // [RULE1]
      else $error("frequency denominator mismatch");
   chk_freq_numer: assert property (CLK_EN_I // [RULE1]
      |=> FREQ_M_O == $past(XTAL_M_I * 48'(fb_q) * (dbl_q ? 48'h2 : 48'h1)))
      else $error("frequency numerator mismatch");
   chk_clock_freeze: assert property (!CLK_EN_I |=> $stable(fb_q) && $stable(lol_q) && $stable(state_q)) // [RULE6]
      else $error("state moved while clock enable low");
   chk_freeze_outputs: assert property (!CLK_EN_I // [RULE6]
      |=> $stable(FREQ_M_O) && $stable(dbl_q) && $stable(src_q) && $stable(fdsrc_q))
      else $error("outputs moved while clock enable low");
endmodule
`default_nettype wire

// >>> verification/spc_mem_model.sv
// Model of the configuration memories read at reset
`timescale 1ns/1ps
`default_nettype none
module spc_mem_model #(
   parameter logic [9:0] OTP_DIV = 10'h110,
   parameter logic [9:0] EE_DIV = 10'h224
) (
   input wire logic bad_otp_i,
   output logic otp_valid_o,
   output logic otp_doubler_o,
   output logic [9:0] otp_fbdiv_o,
   output logic ee_valid_o,
   output logic ee_doubler_o,
   output logic [9:0] ee_fbdiv_o
);
   // Damaged OTP claims valid but holds a divider above range
   assign otp_valid_o = 1'b1;
   assign otp_doubler_o = 1'b1;
   assign otp_fbdiv_o = bad_otp_i ? 10'h22D : OTP_DIV;
   assign ee_valid_o = 1'b1;
   assign ee_doubler_o = 1'b0;
   assign ee_fbdiv_o = EE_DIV;
endmodule
`default_nettype wire

// >>> verification/spc_sys_pll_cfg_tb.sv
// Testbench for the system PLL configuration block
`timescale 1ns/1ps
`default_nettype none
module spc_sys_pll_cfg_tb;
   import spc_pkg::*;
   localparam logic [9:0] OD = 10'h110;
   localparam logic [9:0] ED = 10'h224;
   localparam logic [47:0] XM = 48'h17D7840;
   logic clk = 1'b0, rst = 1'b1, otp_en = 1'b0, ee_en = 1'b0, bad = 1'b0, wr = 1'b0, hdbl = 1'b0, gen = 1'b0;
   logic cen = 1'b1;
   logic [9:0] hdiv = 10'h06C;
   logic [7:0] vc = 8'h80;
   logic ov, od, ev, ed, done, rej, dbl, lol, gpio, fdsrc;
   logic [9:0] odv, edv, div;
   logic [47:0] fm;
   logic [15:0] fn;
   spc_src_t src;
   int err_count = 0, compares = 0, cyc = 0;
   always #2.5 clk = ~clk;
   spc_mem_model #(.OTP_DIV(OD), .EE_DIV(ED)) spc_mem_model_inst (.bad_otp_i(bad), .otp_valid_o(ov),
      .otp_doubler_o(od), .otp_fbdiv_o(odv), .ee_valid_o(ev), .ee_doubler_o(ed), .ee_fbdiv_o(edv));
   spc_sys_pll_cfg #(.VC_W(8)) spc_sys_pll_cfg_inst (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(cen),
      .OTP_EN_I(otp_en), .OTP_VALID_I(ov), .OTP_DOUBLER_I(od), .OTP_FBDIV_I(odv), .EE_EN_I(ee_en),
      .EE_VALID_I(ev), .EE_DOUBLER_I(ed), .EE_FBDIV_I(edv), .HOST_WR_I(wr), .HOST_DOUBLER_I(hdbl),
      .HOST_FBDIV_I(hdiv), .XTAL_M_I(XM), .XTAL_N_I(16'h0001), .LOOP_VCTRL_I(vc), .LOL_GPIO_EN_I(gen),
      .RESET_DONE_O(done), .LOAD_SRC_O(src), .HOST_REJ_O(rej), .DOUBLER_EN_O(dbl), .FBDIV_O(div),
      .FREQ_M_O(fm), .FREQ_N_O(fn), .LOL_STATUS_O(lol), .GPIO_LOL_O(gpio), .FRAC_DIV_SRC_EN_O(fdsrc));
   task automatic end_of_test;
      if (err_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
      compares++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
         err_count++;
      end
   endtask
   task automatic boot(input logic o, input logic e, input logic b);
      @(posedge clk);
      rst <= 1'b1;
      otp_en <= o;
      ee_en <= e;
      bad <= b;
      repeat (3) @(posedge clk);
      chk("div_rst", 48'h06C, div);
      chk("lol_rst", 48'h1, lol);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic t_load;
      boot(1'b1, 1'b1, 1'b0);
      chk("src_otp", SPC_SRC_OTP, src);
      chk("div_otp", OD, div);
      chk("dbl_otp", 48'h1, dbl);
      boot(1'b1, 1'b1, 1'b1);
      chk("src_ee", SPC_SRC_EEPROM, src);
      chk("div_ee", ED, div);
      chk("dbl_ee", 48'h0, dbl);
      boot(1'b0, 1'b0, 1'b0);
      chk("src_none", SPC_SRC_NONE, src);
      chk("div_none", 48'h06C, div);
      chk("done", 48'h1, done);
   endtask
   task automatic hw(input logic d, input logic [9:0] f, input logic r);
      @(posedge clk);
      wr <= 1'b1;
      hdbl <= d;
      hdiv <= f;
      @(negedge clk);
      chk("rej", r, rej);
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic t_host;
      hw(1'b1, 10'h22C, 1'b0);
      hw(1'b0, 10'h06B, 1'b1);
      @(negedge clk);
      chk("div_max", 48'h22C, div);
      chk("dbl_host", 48'h1, dbl);
      hw(1'b1, 10'h06C, 1'b0);
      repeat (2) @(negedge clk);
      chk("freq_m", XM * 48'd2 * 48'h06C, fm);
      chk("freq_n", 48'h1, fn);
   endtask
   // Clock enable low: a host write and a rail voltage must leave everything frozen
   task automatic t_freeze;
      @(posedge clk);
      cen <= 1'b0;
      wr <= 1'b1;
      hdbl <= 1'b0;
      hdiv <= 10'h110;
      vc <= 8'h00;
      repeat (2) @(negedge clk);
      chk("rej_frz", 48'h0, rej);
      chk("div_frz", 48'h06C, div);
      chk("lol_frz", 48'h0, lol);
      @(posedge clk);
      cen <= 1'b1;
      wr <= 1'b0;
      vc <= 8'h80;
      repeat (2) @(negedge clk);
   endtask
   // Window is 128 plus or minus 6 for divider 108 with doubler on
   task automatic t_lock(input logic [7:0] v, input logic g, input logic l);
      @(posedge clk);
      vc <= v;
      gen <= g;
      repeat (2) @(negedge clk);
      chk("lol", l, lol);
      chk("gpio", l & g, gpio);
      chk("fdsrc", !l, fdsrc);
   endtask
   initial begin
      t_load;
      t_host;
      t_freeze;
      t_lock(8'h86, 1'b1, 1'b0);
      t_lock(8'h87, 1'b1, 1'b1);
      t_lock(8'h7A, 1'b0, 1'b0);
      t_lock(8'h79, 1'b0, 1'b1);
      t_lock(8'h00, 1'b1, 1'b1);
      t_lock(8'hFF, 1'b0, 1'b1);
      end_of_test;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         err_count++;
         end_of_test;
      end
   end
endmodule
`default_nettype wire
